// [hw/abo_params.svh]
`ifndef ABO_PARAMS_SVH
`define ABO_PARAMS_SVH
// opcode patterns, matched against the top bits of the 12-bit word
`define ABO_OP_AND_FILE_HI 6'h05
`define ABO_OP_AND_LIT_HI 4'he
`define ABO_OP_BIT_CLR_HI 4'h4
`define ABO_OP_BIT_SET_HI 4'h5
// field positions
`define ABO_INSTR_MSB 11
`define ABO_OP6_LSB 6
`define ABO_OP4_LSB 8
`define ABO_LIT_LSB 0
`define ABO_ADDR_LSB 0
`define ABO_ADDR_MSB 4
`define ABO_DEST_BIT 5
`define ABO_BIT_LSB 5
`define ABO_BIT_MSB 7
`define ABO_LIT_MSB 7
// file register addresses handled specially
`define ABO_TIMER_ADDR 5'h01
`define ABO_PORT_FIRST 5'h05
`define ABO_PORT_LAST 5'h07
// byte constants
`define ABO_BIT_ONE 8'h01
`define ABO_ZERO_BYTE 8'h00
// reset values; w starts all ones because this block can only clear bits of it
`define ABO_W_RESET 8'hff
`define ABO_Z_RESET 1'b0
`endif

// [hw/abo_pkg.sv]
package abo_pkg;
  typedef enum logic [1:0] {
    ABO_OP_NONE = 2'b00,
    ABO_OP_AND_F = 2'b01,
    ABO_OP_AND_L = 2'b11,
    ABO_OP_BIT = 2'b10
  } abo_op_t;

  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } abo_file_wr_t;
endpackage : abo_pkg

// [hw/abo_exec.sv]
`timescale 1ns/10ps
`include "abo_params.svh"
// Behaviour
// - register-AND: W AND file register at 5-bit address 0..31.
// - register-AND destination bit 0 writes W, 1 writes file register.
// - literal-AND: W AND low-byte literal into W, one cycle.
// - bit-clear: zero selected bit of file register, flags unchanged, one cycle.
// - bit-set: set selected bit of file register, flags unchanged, one cycle.
// - read-modify-write on port register uses pin levels, not latch.
// - writing timer register clears prescaler when assigned to timer.
module abo_exec
  import abo_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  output logic [4:0] file_raddr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] port_pins,
  input wire logic prescaler_to_timer,
  output abo_file_wr_t file_wr_q,
  output logic [7:0] w_q,
  output logic zero_q,
  output logic prescaler_clr_q,
  output logic done_q
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // the register-AND shares its top nibble with other opcodes, so it is
  // matched on six bits before the four-bit patterns are tried
  function automatic abo_op_t decode_op(input logic [11:0] word);
    abo_op_t kind;
    kind = ABO_OP_NONE;
    if (word[`ABO_INSTR_MSB:`ABO_OP6_LSB] == `ABO_OP_AND_FILE_HI) begin
      kind = ABO_OP_AND_F;
    end else if (word[`ABO_INSTR_MSB:`ABO_OP4_LSB] == `ABO_OP_AND_LIT_HI) begin
      kind = ABO_OP_AND_L;
    end else if (word[`ABO_INSTR_MSB:`ABO_OP4_LSB] == `ABO_OP_BIT_CLR_HI) begin
      kind = ABO_OP_BIT;
    end else if (word[`ABO_INSTR_MSB:`ABO_OP4_LSB] == `ABO_OP_BIT_SET_HI) begin
      kind = ABO_OP_BIT;
    end
    decode_op = kind;
  endfunction : decode_op

  function automatic logic is_bit_set(input logic [11:0] word);
    is_bit_set = (word[`ABO_INSTR_MSB:`ABO_OP4_LSB] == `ABO_OP_BIT_SET_HI);
  endfunction : is_bit_set

  // only the port window reads pins; everything else reads the file
  function automatic logic is_port(input logic [4:0] a);
    is_port = (a >= `ABO_PORT_FIRST) && (a <= `ABO_PORT_LAST);
  endfunction : is_port

  function automatic logic [7:0] bit_mask_of(input logic [2:0] pos);
    bit_mask_of = `ABO_BIT_ONE << pos;
  endfunction : bit_mask_of

  function automatic logic [7:0] apply_bit(input logic [7:0] value, input logic [2:0] pos, input logic set);
    logic [7:0] mask;
    mask = bit_mask_of(pos);
    if (set) begin
      apply_bit = value | mask;
    end else begin
      apply_bit = value & ~mask;
    end
  endfunction : apply_bit

  function automatic logic is_zero_byte(input logic [7:0] value);
    is_zero_byte = (value == `ABO_ZERO_BYTE);
  endfunction : is_zero_byte

  function automatic logic writes_file(input abo_op_t kind, input logic dest);
    case (kind)
      ABO_OP_AND_F: begin
        writes_file = dest;
      end
      ABO_OP_BIT: begin
        writes_file = 1'b1;
      end
      default: begin
        writes_file = 1'b0;
      end
    endcase
  endfunction : writes_file

  function automatic logic writes_w(input abo_op_t kind, input logic dest);
    case (kind)
      ABO_OP_AND_F: begin
        writes_w = !dest;
      end
      ABO_OP_AND_L: begin
        writes_w = 1'b1;
      end
      default: begin
        writes_w = 1'b0;
      end
    endcase
  endfunction : writes_w

  function automatic logic updates_zero(input abo_op_t kind);
    case (kind)
      ABO_OP_AND_F, ABO_OP_AND_L: begin
        updates_zero = 1'b1;
      end
      default: begin
        updates_zero = 1'b0;
      end
    endcase
  endfunction : updates_zero

  ////////////////////////////////////////////////////////////////////////////
  // instruction fields

  abo_op_t op;
  logic set_not_clear;
  logic [4:0] addr;
  logic dest_file;
  logic [2:0] bit_pos;
  logic [7:0] literal;

  // a word with instr_valid low is dropped whole, never half decoded
  always_comb begin
    op = ABO_OP_NONE;
    set_not_clear = 1'b0;
    if (instr_valid) begin
      op = decode_op(instr);
      set_not_clear = is_bit_set(instr);
    end
  end

  assign addr = instr[`ABO_ADDR_MSB:`ABO_ADDR_LSB];
  assign dest_file = instr[`ABO_DEST_BIT];
  assign bit_pos = instr[`ABO_BIT_MSB:`ABO_BIT_LSB];
  assign literal = instr[`ABO_LIT_MSB:`ABO_LIT_LSB];
  assign file_raddr = addr;

  ////////////////////////////////////////////////////////////////////////////
  // operand and result

  // ports are read back from the pins so inputs driven low externally stick
  logic [7:0] operand;
  logic [7:0] second;
  logic [7:0] and_result;
  logic [7:0] bit_result;

  assign operand = is_port(addr) ? port_pins : file_rdata;
  assign second = (op == ABO_OP_AND_L) ? literal : operand;
  assign and_result = w_q & second;
  assign bit_result = apply_bit(operand, bit_pos, set_not_clear);

  ////////////////////////////////////////////////////////////////////////////
  // write enables

  logic file_we;
  logic w_we;
  logic zero_we;
  logic timer_hit;

  assign file_we = writes_file(op, dest_file);
  assign w_we = writes_w(op, dest_file);
  assign zero_we = updates_zero(op);
  // a register-AND into w only reads the timer, so it leaves the prescaler alone
  assign timer_hit = file_we && (addr == `ABO_TIMER_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // working register

  // w is loaded elsewhere in the core; here it can only lose bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_q <= `ABO_W_RESET;
    end else if (w_we) begin
      w_q <= and_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero flag

  // bit ops leave the flag alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_q <= `ABO_Z_RESET;
    end else if (zero_we) begin
      zero_q <= is_zero_byte(and_result);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file write-back

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      file_wr_q.en <= 1'b0;
    end else begin
      file_wr_q.en <= file_we;
    end
  end

  // address and data follow every cycle; only en qualifies them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      file_wr_q.addr <= '0;
      file_wr_q.data <= '0;
    end else begin
      file_wr_q.addr <= addr;
      if (op == ABO_OP_BIT) begin
        file_wr_q.data <= bit_result;
      end else begin
        file_wr_q.data <= and_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler clear and completion

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prescaler_clr_q <= 1'b0;
    end else begin
      prescaler_clr_q <= timer_hit && prescaler_to_timer;
    end
  end

  // every handled instruction finishes in a single cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (op != ABO_OP_NONE);
    end
  end

endmodule : abo_exec

// [verif/abo_exec_props.sv]
`timescale 1ns/10ps
module abo_exec_props
  import abo_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic instr_valid,
  input logic [11:0] instr,
  input logic [4:0] file_raddr,
  input logic [7:0] file_rdata,
  input logic [7:0] port_pins,
  input logic prescaler_to_timer,
  input abo_file_wr_t file_wr_q,
  input logic [7:0] w_q,
  input logic zero_q,
  input logic prescaler_clr_q,
  input logic done_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire fa = instr_valid && instr[11:6] == 6'h05, la = instr_valid && instr[11:8] == 4'he;
  wire ca = instr_valid && instr[11:8] == 4'h4, sa = instr_valid && instr[11:8] == 4'h5;
  // port addresses read the pins, so a driven-low input is written back low
  wire [7:0] op = file_raddr inside {[5'h05:5'h07]} ? port_pins : file_rdata;
  wire [7:0] rf = w_q & op, rl = w_q & instr[7:0];
  wire [7:0] bc = op & ~(8'h01 << instr[7:5]), bs = op | (8'h01 << instr[7:5]);
  wire tw = (ca || sa || (fa && instr[5])) && file_raddr == 5'h01 && prescaler_to_timer;
  wire any = fa || la || ca || sa;
  AST_AND_W: assert property (fa && !instr[5] |=> w_q == $past(rf) && !file_wr_q.en) else $error("andw");
  AST_AND_F: assert property (fa && instr[5] |=> file_wr_q.en && file_wr_q.data == $past(rf)) else $error("andf");
  AST_ZERO_F: assert property (fa |=> zero_q == !$past(rf)) else $error("zf");
  AST_AND_L: assert property (la |=> w_q == $past(rl) && zero_q == !$past(rl)) else $error("andl");
  AST_CLR: assert property (ca |=> file_wr_q.en && file_wr_q.data == $past(bc)) else $error("clr");
  AST_SET: assert property (sa |=> file_wr_q.en && file_wr_q.data == $past(bs)) else $error("set");
  AST_KEEP: assert property (!(fa || la) |=> $stable(zero_q)) else $error("keep");
  AST_PRE: assert property (tw |=> prescaler_clr_q) else $error("pre");
  AST_NO_PRE: assert property (!tw |=> !prescaler_clr_q) else $error("no pre");
  AST_DONE: assert property (any |=> done_q) else $error("done");
  AST_IDLE: assert property (!any |=> !done_q && !file_wr_q.en && $stable(w_q)) else $error("idle");
  cover property (fa && instr[5]);
  cover property (ca && file_raddr inside {[5'h05:5'h07]});
  cover property (la);
  cover property (sa && prescaler_to_timer);
endmodule : abo_exec_props
bind abo_exec abo_exec_props u_props (.*);

// [verif/and_and_bit_set_clear_ops_tb.sv]
`timescale 1ns/10ps
module and_and_bit_set_clear_ops_tb
  import abo_pkg::*;
;
  typedef struct packed {
    logic [11:0] instr;
    logic [7:0] fdata;
    logic [7:0] pins;
    logic pre;
    logic en;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [7:0] w;
    logic zero;
    logic clr;
    logic done;
  } abo_row_t;

  localparam int NROWS = 12;
  localparam abo_row_t RESET_ROW = '{12'h000, 8'h00, 8'h00, 1'b0, 1'b0, 5'h00, 8'h00, 8'hff, 1'b0, 1'b0, 1'b0};
  localparam abo_row_t LIT_ROW = '{12'he81, 8'h00, 8'h00, 1'b0, 1'b0, 5'h00, 8'h00, 8'h81, 1'b0, 1'b0, 1'b1};
  localparam abo_row_t LIT_IDLE_ROW = '{12'h000, 8'h00, 8'h00, 1'b0, 1'b0, 5'h00, 8'h00, 8'h81, 1'b0, 1'b0, 1'b0};

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] port_pins = 8'h00;
  logic prescaler_to_timer = 1'b0;
  logic [4:0] file_raddr;
  abo_file_wr_t file_wr_q;
  logic [7:0] w_q;
  logic zero_q;
  logic prescaler_clr_q;
  logic done_q;
  int miscompares = 0;
  int samples_checked = 0;

  // instr, file data, pins, prescaler owner | write en, addr, data, w, zero, clear, done
  // w starts at all ones and only loses bits, so the rows must run in this order
  abo_row_t rows [NROWS] = '{
    '{12'h4e3, 8'hc7, 8'h5a, 1'b0, 1'b1, 5'h03, 8'h47, 8'hff, 1'b0, 1'b0, 1'b1},
    '{12'h501, 8'h00, 8'h5a, 1'b1, 1'b1, 5'h01, 8'h01, 8'hff, 1'b0, 1'b1, 1'b1},
    '{12'h506, 8'hff, 8'h10, 1'b1, 1'b1, 5'h06, 8'h11, 8'hff, 1'b0, 1'b0, 1'b1},
    '{12'h162, 8'h3c, 8'h00, 1'b0, 1'b1, 5'h02, 8'h3c, 8'hff, 1'b0, 1'b0, 1'b1},
    '{12'h161, 8'ha5, 8'h00, 1'b1, 1'b1, 5'h01, 8'ha5, 8'hff, 1'b0, 1'b1, 1'b1},
    '{12'h165, 8'hff, 8'h0f, 1'b0, 1'b1, 5'h05, 8'h0f, 8'hff, 1'b0, 1'b0, 1'b1},
    '{12'he5f, 8'h00, 8'h00, 1'b0, 1'b0, 5'h1f, 8'h00, 8'h5f, 1'b0, 1'b0, 1'b1},
    '{12'h144, 8'hc3, 8'h00, 1'b0, 1'b0, 5'h04, 8'h00, 8'h43, 1'b0, 1'b0, 1'b1},
    '{12'he3c, 8'h00, 8'h00, 1'b0, 1'b0, 5'h1c, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1},
    '{12'h5ff, 8'h00, 8'h00, 1'b0, 1'b1, 5'h1f, 8'h80, 8'h00, 1'b1, 1'b0, 1'b1},
    '{12'h401, 8'hff, 8'h00, 1'b0, 1'b1, 5'h01, 8'hfe, 8'h00, 1'b1, 1'b0, 1'b1},
    '{12'h141, 8'hff, 8'h00, 1'b1, 1'b0, 5'h01, 8'h00, 8'h00, 1'b1, 1'b0, 1'b1}
  };

  abo_exec u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .instr_valid(instr_valid),
    .instr(instr),
    .file_raddr(file_raddr),
    .file_rdata(file_rdata),
    .port_pins(port_pins),
    .prescaler_to_timer(prescaler_to_timer),
    .file_wr_q(file_wr_q),
    .w_q(w_q),
    .zero_q(zero_q),
    .prescaler_clr_q(prescaler_clr_q),
    .done_q(done_q)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // the whole run is about thirty cycles; this is several times that
  initial begin
    #5000;
    miscompares++;
    stop_test();
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic check_row(input abo_row_t r);
    chk(8'(file_wr_q.en), 8'(r.en));
    if (r.en) begin
      chk(8'(file_wr_q.addr), 8'(r.waddr));
      chk(file_wr_q.data, r.wdata);
    end
    chk(w_q, r.w);
    chk(8'(zero_q), 8'(r.zero));
    chk(8'(prescaler_clr_q), 8'(r.clr));
    chk(8'(done_q), 8'(r.done));
  endtask : check_row

  task automatic stop_test();
    $display("checks %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check_row(RESET_ROW);
    for (int i = 0; i <= NROWS; i++) begin
      @(posedge clk);
      if (i < NROWS) begin
        instr_valid <= 1'b1;
        instr <= rows[i].instr;
        file_rdata <= rows[i].fdata;
        port_pins <= rows[i].pins;
        prescaler_to_timer <= rows[i].pre;
      end else begin
        instr_valid <= 1'b0;
      end
      #1;
      if (i > 0) begin
        check_row(rows[i - 1]);
      end
    end
    // mid-run reset brings w back to all ones and clears the flag
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    check_row(RESET_ROW);
    // first word after release is an opcode this block does not handle
    @(posedge clk);
    rst_n <= 1'b1;
    instr_valid <= 1'b1;
    instr <= 12'h643;
    file_rdata <= 8'h00;
    prescaler_to_timer <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    instr <= 12'he00;
    #1;
    check_row(RESET_ROW);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= 12'he81;
    #1;
    check_row(RESET_ROW);
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    check_row(LIT_ROW);
    @(posedge clk);
    #1;
    check_row(LIT_IDLE_ROW);
    stop_test();
  end
endmodule : and_and_bit_set_clear_ops_tb
